// ### logic/supply_monitor_pkg.sv
// Package: register map, field layout, reset values and timing for the supply monitor
package supply_monitor_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [4:0] OFS_CONTROL  = 5'h00;
  localparam logic [4:0] OFS_LEVEL    = 5'h04;
  localparam logic [4:0] OFS_CAUSE    = 5'h08;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h0c;
  localparam logic [4:0] OFS_IRQ_MSK  = 5'h10;

  // Control register fields
  localparam int CTL_FLAG_BIT   = 0;
  localparam int CTL_RESP_BIT   = 1;
  localparam int CTL_SRC_BIT    = 2;
  localparam int CTL_ENABLE_BIT = 7;

  // Reset-cause register fields
  localparam int CAUSE_BROWNOUT_BIT = 0;
  localparam int CAUSE_WATCHDOG_BIT = 4;

  // Interrupt status fields
  localparam int IRQ_CROSS_BIT = 0;

  // Reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [3:0] LEVEL_RST   = 4'h0;
  localparam logic [7:0] CAUSE_RST   = 8'h00;
  localparam logic [7:0] IRQ_RST     = 8'h00;

  // Timing at 25 MHz
  localparam int CLK_HZ            = 25000000;
  localparam int FAST_RISE_US      = 1930;
  localparam int STAB_WAIT_US      = 5390;
  localparam int FAST_RISE_CYCLES  = (FAST_RISE_US * (CLK_HZ / 1000000));
  localparam int STAB_WAIT_CYCLES  = (STAB_WAIT_US * (CLK_HZ / 1000000));

  // Synchronised comparator results
  typedef struct packed {
    logic above_por_low;
    logic above_por_high;
    logic below_supply;
    logic below_ext;
  } compare_s;

  typedef enum logic [1:0] {
    POR_HOLD,
    POR_RISING,
    POR_STABILISE,
    POR_RUN
  } por_state_e;

endpackage

// ### logic/supply_monitor_reset_interrupt.sv
// Supply monitor: power-on clear, brown-out detector, reset cause and interrupt
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module supply_monitor_reset_interrupt
  import supply_monitor_pkg::*;
#(
  parameter int FAST_RISE_LIMIT = FAST_RISE_CYCLES,
  parameter int STAB_WAIT_LIMIT = STAB_WAIT_CYCLES
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Power-on threshold option strap
  input  wire logic        power_on_threshold_option,
  // Analog compare results (asynchronous)
  input  wire logic        cmp_above_por_low,
  input  wire logic        cmp_above_por_high,
  input  wire logic        cmp_below_supply,
  input  wire logic        cmp_below_ext,
  // Other reset sources
  input  wire logic        watchdog_reset_req,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Analog control and system outputs
  output logic             comparator_enable,
  output logic             external_sense_select,
  output logic [3:0]       supply_detect_level,
  output logic             internal_reset,
  output logic             detector_interrupt,
  output logic             irq
);

  // Reset release synchroniser, two stages
  logic       rst_s1;
  logic       rst_n;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // Three-stage synchronisers; a change counts once stages two and three agree
  compare_s sync1;
  compare_s sync2;
  compare_s sync3;
  compare_s cmp;
  compare_s next_cmp;
  logic [2:0] opt_sync;
  always_comb begin
    next_cmp = cmp;
    if (sync2 == sync3) begin
      next_cmp = sync3;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      cmp   <= '0;
      opt_sync <= 3'h0;
    end else begin
      sync1 <= {cmp_above_por_low, cmp_above_por_high, cmp_below_supply, cmp_below_ext};
      sync2 <= sync1;
      sync3 <= sync2;
      cmp   <= next_cmp;
      // Strap is a pin too, so it gets the same three stages
      opt_sync <= {opt_sync[1:0], power_on_threshold_option};
    end
  end

  // Power-on clear sequencer; strap sampled at every reset hold
  por_state_e por_state;
  por_state_e next_por_state;
  logic       option;
  logic       next_option;
  logic [17:0] por_cnt;
  logic [17:0] next_por_cnt;
  logic       por_reset;

  function automatic logic [17:0] inc18(input logic [17:0] v);
    return v + 18'h00001;
  endfunction

  always_comb begin
    next_por_state = por_state;
    next_por_cnt   = por_cnt;
    next_option    = option;
    case (por_state)
      POR_HOLD: begin
        next_por_cnt = '0;
        if (opt_sync[1] == opt_sync[2]) begin
          next_option = opt_sync[2];
        end
        if (cmp.above_por_low) begin
          if (!option) begin
            next_por_state = POR_RUN;
          end else begin
            next_por_state = POR_RISING;
          end
        end
      end
      POR_RISING: begin
        next_por_cnt = inc18(por_cnt);
        if (!cmp.above_por_low) begin
          next_por_state = POR_HOLD;
        end else if (cmp.above_por_high) begin
          if (por_cnt < 18'(FAST_RISE_LIMIT)) begin
            next_por_state = POR_STABILISE;
            next_por_cnt   = '0;
          end else begin
            next_por_state = POR_RUN;
          end
        end
      end
      POR_STABILISE: begin
        next_por_cnt = inc18(por_cnt);
        if (!cmp.above_por_low) begin
          next_por_state = POR_HOLD;
        end else if (por_cnt >= 18'(STAB_WAIT_LIMIT - 1)) begin
          next_por_state = POR_RUN;
        end
      end
      POR_RUN: begin
        if (!cmp.above_por_low) begin
          next_por_state = POR_HOLD;
        end
      end
      default: next_por_state = POR_HOLD;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_state <= POR_HOLD;
      por_cnt   <= '0;
      option    <= 1'b0;
    end else begin
      por_state <= next_por_state;
      por_cnt   <= next_por_cnt;
      option    <= next_option;
    end
  end
  assign por_reset = (por_state != POR_RUN);

  // Detector state and registers; runs on ref_clk only, independent of CPU STOP
  logic       det_enable;
  logic       det_source;
  logic       det_response;
  logic [3:0] level;
  logic [7:0] cause;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic       below;
  logic       below_d;
  logic       det_reset;
  logic       ack;
  logic [31:0] rdata;
  logic       next_det_enable;
  logic       next_det_source;
  logic       next_det_response;
  logic [3:0] next_level;
  logic [7:0] next_cause;
  logic [7:0] next_irq_status;
  logic [7:0] next_irq_mask;
  logic       next_below_d;
  logic       next_det_reset;
  logic       next_ack;
  logic [31:0] next_rdata;
  logic       next_det_irq;
  logic       next_irq;
  logic       next_int_reset;
  logic       wr;
  logic       rd;
  logic       other_reset;

  // Selected compare, gated by enable
  always_comb begin
    below = det_enable & (det_source ? cmp.below_ext : cmp.below_supply);
  end

  always_comb begin
    wr                = wb_cyc_i & wb_stb_i & wb_we_i & !ack & wb_sel_i[0];
    rd                = wb_cyc_i & wb_stb_i & !wb_we_i & !ack;
    other_reset       = por_reset | watchdog_reset_req;
    next_det_enable   = det_enable;
    next_det_source   = det_source;
    next_det_response = det_response;
    next_level        = level;
    next_cause        = cause;
    next_irq_status   = irq_status;
    next_irq_mask     = irq_mask;
    next_below_d      = below;
    next_det_irq      = 1'b0;
    next_ack          = wb_cyc_i & wb_stb_i & !ack;
    next_rdata        = '0;
    next_det_reset    = det_response & below;

    // Register writes
    if (wr) begin
      case (wb_adr_i)
        OFS_CONTROL: begin
          next_det_enable   = wb_dat_i[CTL_ENABLE_BIT];
          next_det_source   = wb_dat_i[CTL_SRC_BIT];
          next_det_response = wb_dat_i[CTL_RESP_BIT];
        end
        OFS_LEVEL:    next_level = wb_dat_i[3:0];
        OFS_IRQ_STAT: next_irq_status = irq_status & ~wb_dat_i[7:0];
        OFS_IRQ_MSK:  next_irq_mask = wb_dat_i[7:0];
        default: ;
      endcase
    end

    // Crossings in interrupt mode; set wins over clear
    if (!det_response && det_enable && (below != below_d)) begin
      next_det_irq = 1'b1;
      next_irq_status[IRQ_CROSS_BIT] = 1'b1;
    end

    // Reads
    if (rd) begin
      case (wb_adr_i)
        OFS_CONTROL: begin
          next_rdata[CTL_ENABLE_BIT] = det_enable;
          next_rdata[CTL_SRC_BIT]    = det_source;
          next_rdata[CTL_RESP_BIT]   = det_response;
          next_rdata[CTL_FLAG_BIT]   = below;
        end
        OFS_LEVEL:    next_rdata[3:0] = level;
        OFS_CAUSE:    next_rdata[7:0] = cause;
        OFS_IRQ_STAT: next_rdata[7:0] = irq_status;
        OFS_IRQ_MSK:  next_rdata[7:0] = irq_mask;
        default:      next_rdata = '0;
      endcase
    end

    // Reset cause tracking
    if (det_reset) begin
      next_cause[CAUSE_BROWNOUT_BIT] = 1'b1;
    end
    if (watchdog_reset_req) begin
      next_cause[CAUSE_WATCHDOG_BIT] = 1'b1;
    end
    if (por_reset) begin
      next_cause = CAUSE_RST;
    end

    // Non-detector resets clear detector settings
    if (other_reset) begin
      next_det_enable   = CONTROL_RST[CTL_ENABLE_BIT];
      next_det_source   = CONTROL_RST[CTL_SRC_BIT];
      next_det_response = CONTROL_RST[CTL_RESP_BIT];
      next_level        = LEVEL_RST;
      next_irq_status   = IRQ_RST;
      next_irq_mask     = IRQ_RST;
      next_det_reset    = 1'b0;
    end

    next_int_reset = other_reset | det_reset;
    next_irq       = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      det_enable         <= 1'b0;
      det_source         <= 1'b0;
      det_response       <= 1'b0;
      level              <= LEVEL_RST;
      cause              <= CAUSE_RST;
      irq_status         <= IRQ_RST;
      irq_mask           <= IRQ_RST;
      below_d            <= 1'b0;
      det_reset          <= 1'b0;
      ack                <= 1'b0;
      rdata              <= '0;
      internal_reset     <= 1'b1;
      detector_interrupt <= 1'b0;
      irq                <= 1'b0;
    end else begin
      det_enable         <= next_det_enable;
      det_source         <= next_det_source;
      det_response       <= next_det_response;
      level              <= next_level;
      cause              <= next_cause;
      irq_status         <= next_irq_status;
      irq_mask           <= next_irq_mask;
      below_d            <= next_below_d;
      det_reset          <= next_det_reset;
      ack                <= next_ack;
      rdata              <= next_rdata;
      internal_reset     <= next_int_reset;
      detector_interrupt <= next_det_irq;
      irq                <= next_irq;
    end
  end

  // Analog drive registered so every output comes from a flip-flop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      comparator_enable     <= 1'b0;
      external_sense_select <= 1'b0;
      supply_detect_level   <= LEVEL_RST;
    end else begin
      comparator_enable     <= next_det_enable;
      external_sense_select <= next_det_source;
      supply_detect_level   <= next_level;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;

endmodule
`default_nettype wire

// ### testbench/supply_monitor_properties.sv
// Port checker for the supply monitor
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_properties (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       resetn,
  // Inputs
  input wire logic       power_on_threshold_option,
  input wire logic       cmp_above_por_low,
  input wire logic       cmp_above_por_high,
  input wire logic       watchdog_reset_req,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  // Outputs
  input wire logic       wb_ack_o,
  input wire logic       comparator_enable,
  input wire logic       external_sense_select,
  input wire logic [3:0] supply_detect_level,
  input wire logic       internal_reset,
  input wire logic       detector_interrupt,
  input wire logic       irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_por_holds: assert property (!cmp_above_por_low [*8] |-> internal_reset)
    else $error("reset not held below threshold");
  a_low_release: assert property ($fell(internal_reset) |-> cmp_above_por_low)
    else $error("reset released below threshold");
  a_high_release: assert property (
    $fell(internal_reset) && power_on_threshold_option && !$past(comparator_enable, 3)
    && !$past(watchdog_reset_req, 2) |-> cmp_above_por_high)
    else $error("reset released below upper threshold");
  a_int_pulse: assert property (detector_interrupt |=> !detector_interrupt)
    else $error("interrupt is not a pulse");
  a_int_disabled: assert property (!comparator_enable [*8] |-> !detector_interrupt)
    else $error("interrupt while disabled");
  a_por_clears: assert property (
    !cmp_above_por_low [*8] |-> !comparator_enable && supply_detect_level == 4'h0)
    else $error("settings kept through power-on reset");
  a_wdog_clears: assert property (watchdog_reset_req |-> ##[1:3] !comparator_enable)
    else $error("watchdog did not clear enable");
  a_level_write: assert property ($changed(supply_detect_level) |-> wb_ack_o
    || internal_reset || $past(internal_reset) || $past(watchdog_reset_req))
    else $error("level changed without a write");
  a_source_write: assert property (!wb_ack_o && !internal_reset
    && !$past(internal_reset) && !$past(watchdog_reset_req) |-> $stable(external_sense_select))
    else $error("source changed without a write");
  c_interrupt: cover property (detector_interrupt);
  c_high_release: cover property ($fell(internal_reset) && power_on_threshold_option);
  c_irq: cover property (irq);
endmodule
bind supply_monitor_reset_interrupt supply_monitor_properties chk_props (.*);
`default_nettype wire

// ### testbench/analog_compare_model.sv
// Analog comparator model for supply, threshold and sense levels
`timescale 1ns/1ps
`default_nettype none
module analog_compare_model (
  // Analog levels in millivolts
  input var int          supply_mv,
  input var int          ext_mv,
  // Controls from the block
  input wire logic       comparator_enable,
  input wire logic [3:0] supply_detect_level,
  // Compare results
  output logic           cmp_above_por_low,
  output logic           cmp_above_por_high,
  output logic           cmp_below_supply,
  output logic           cmp_below_ext
);
  localparam int LVL_MV [16] = '{4240, 4090, 3930, 3780, 3620, 3470, 3320, 3160,
    3010, 2850, 2700, 2550, 2390, 2240, 2080, 1930};
  // A stopped comparator settles low
  always_comb begin
    cmp_above_por_low = supply_mv >= 1590;
    cmp_above_por_high = supply_mv >= 2700;
    cmp_below_supply = comparator_enable && supply_mv < LVL_MV[supply_detect_level];
    cmp_below_ext = comparator_enable && ext_mv < 1210;
  end
endmodule
`default_nettype wire

// ### testbench/tb_supply_monitor_reset_interrupt.sv
// Testbench for the supply monitor
`timescale 1ns/1ps
`default_nettype none
module tb_supply_monitor_reset_interrupt import supply_monitor_pkg::*; ;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        opt = 1'b0;
  logic        wdog = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat, rd;
  logic        ack, ce, ess, irst, dint, irq, c_lo, c_hi, c_bs, c_be;
  logic [3:0]  lvl;
  int          supply_mv = 0;
  int          ext_mv = 1500;
  int          err_count = 0;
  int          tests_run = 0;
  int          cyc_n = 0;
  always #20 ref_clk = ~ref_clk;
  supply_monitor_reset_interrupt #(.FAST_RISE_LIMIT(20), .STAB_WAIT_LIMIT(50)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .power_on_threshold_option(opt),
    .cmp_above_por_low(c_lo), .cmp_above_por_high(c_hi), .cmp_below_supply(c_bs),
    .cmp_below_ext(c_be), .watchdog_reset_req(wdog), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .comparator_enable(ce), .external_sense_select(ess),
    .supply_detect_level(lvl), .internal_reset(irst), .detector_interrupt(dint), .irq(irq));
  analog_compare_model far (.supply_mv(supply_mv), .ext_mv(ext_mv), .comparator_enable(ce),
    .supply_detect_level(lvl), .cmp_above_por_low(c_lo), .cmp_above_por_high(c_hi),
    .cmp_below_supply(c_bs), .cmp_below_ext(c_be));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Waits on ack with no assumed latency; looks mid-cycle, away from the launching edge
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(negedge ref_clk);
    while (ack !== 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    rd = rdat;
    @(posedge ref_clk);
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge ref_clk);
    if (n >= 50) chk(32'h1, 32'h0);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wait_rst(input logic v, input int lim);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (irst !== v && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    chk(irst, v);
    @(posedge ref_clk);
  endtask
  // Pulse lasts one cycle, so look at every falling edge
  task automatic pulse;
    int n;
    n = 0;
    @(negedge ref_clk);
    while (dint !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    chk(dint, 1'b1);
    @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    cycles(10);
    resetn <= 1'b1;
    cycles(5);
    chk(irst, 1'b1);
    supply_mv <= 3300;
    wait_rst(1'b0, 30);
    rdchk(OFS_CONTROL, 32'(CONTROL_RST));
    rdchk(OFS_LEVEL, {28'h0, LEVEL_RST});
    rdchk(OFS_CAUSE, 32'(CAUSE_RST));
    rdchk(5'h14, 32'h0);
    wb(1'b1, OFS_LEVEL, 32'h0a);
    chk(lvl, 4'ha);
    rdchk(OFS_LEVEL, 32'h0a);
    wb(1'b1, OFS_CONTROL, 32'h82);
    chk(ce, 1'b1);
    supply_mv <= 2600;
    wait_rst(1'b1, 30);
    supply_mv <= 3300;
    wait_rst(1'b0, 30);
    rdchk(OFS_CAUSE, 32'h01);
    rdchk(OFS_CONTROL, 32'h82);
    wb(1'b1, OFS_IRQ_MSK, 32'h1);
    wb(1'b1, OFS_CONTROL, 32'h84);
    chk(ess, 1'b1);
    cycles(10);
    wb(1'b1, OFS_IRQ_STAT, 32'h1);
    ext_mv <= 1000;
    pulse();
    rdchk(OFS_CONTROL, 32'h85);
    rdchk(OFS_IRQ_STAT, 32'h1);
    chk(irq, 1'b1);
    wb(1'b1, OFS_IRQ_STAT, 32'h1);
    chk(irq, 1'b0);
    ext_mv <= 1500;
    pulse();
    chk(irst, 1'b0);
    cycles(3);
    chk(irq, 1'b1);
    wb(1'b1, OFS_IRQ_MSK, 32'h0);
    chk(irq, 1'b0);
    ext_mv <= 1000;
    cycles(10);
    wb(1'b1, OFS_CONTROL, 32'h00);
    cycles(10);
    rdchk(OFS_CONTROL, 32'h0);
    wb(1'b1, OFS_CONTROL, 32'h82);
    wdog <= 1'b1;
    cycles(3);
    wdog <= 1'b0;
    wait_rst(1'b0, 30);
    rdchk(OFS_CONTROL, 32'h0);
    rdchk(OFS_CAUSE, 32'h11);
    supply_mv <= 1000;
    wait_rst(1'b1, 30);
    opt <= 1'b1;
    supply_mv <= 2000;
    cycles(40);
    chk(irst, 1'b1);
    supply_mv <= 3000;
    wait_rst(1'b0, 30);
    supply_mv <= 1000;
    wait_rst(1'b1, 30);
    supply_mv <= 3000;
    cycles(40);
    chk(irst, 1'b1);
    wait_rst(1'b0, 60);
    rdchk(OFS_CAUSE, 32'h0);
    rdchk(OFS_LEVEL, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
